// ===== rtl/macdp_top.sv
// multiply-accumulate datapath with its status flags and AHB-Lite registers
`timescale 1ns/1ns

module macdp_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // core issue port
  input  wire logic        op_valid,
  input  wire logic [2:0]  op_code,
  input  wire logic        acc_select_b,
  input  wire logic        op_subtract,
  input  wire logic        x_signed,
  input  wire logic        y_signed,
  input  wire logic        byte_operands,
  input  wire logic [15:0] x_operand,
  input  wire logic [15:0] y_operand,
  input  wire logic        use_shifted_data,
  input  wire logic [39:0] raw_data,
  input  wire logic [39:0] shifted_data,
  // results
  output logic      [39:0] accumulator_a,
  output logic      [39:0] accumulator_b,
  output logic      [31:0] mul_result,
  output logic             mul_done,
  output logic             acc_a_guard_overflow,
  output logic             acc_b_guard_overflow,
  output logic             acc_a_saturated,
  output logic             acc_b_saturated,
  output logic             any_guard_overflow,
  output logic             any_saturated,
  output logic             arith_warning_trap
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // guard bits and sign all equal means the value fits the low part
  function automatic logic fits32(input logic [39:0] v);
    fits32 = (v[39:31] == 9'h000) || (v[39:31] == 9'h1FF);
  endfunction

  function automatic logic guard_mixed(input logic [39:0] v);
    guard_mixed = !((v[39:32] == 8'h00) || (v[39:32] == 8'hFF));
  endfunction

  function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn);
    ext17 = {sgn & v[15], v};
  endfunction

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [3:0]  core_control_reg;
  logic [2:0]  trap_control_reg;
  logic [1:0]  per_acc_saturation_enable;
  logic        wide_saturation_select;
  logic        frac_mode;
  logic        acc_a_overflow_trap_en;
  logic        acc_b_overflow_trap_en;
  logic        catastrophic_overflow_trap_en;

  assign per_acc_saturation_enable = {core_control_reg[macdp_pkg::SAT_EN_B_BIT],
                                      core_control_reg[macdp_pkg::SAT_EN_A_BIT]};
  assign wide_saturation_select        = core_control_reg[macdp_pkg::WIDE_SAT_BIT];
  assign frac_mode                     = core_control_reg[macdp_pkg::FRAC_MODE_BIT];
  assign acc_a_overflow_trap_en        = trap_control_reg[macdp_pkg::OVA_TRAP_BIT];
  assign acc_b_overflow_trap_en        = trap_control_reg[macdp_pkg::OVB_TRAP_BIT];
  assign catastrophic_overflow_trap_en = trap_control_reg[macdp_pkg::COV_TRAP_BIT];

  // ---------------------------------------------------------------
  // AHB-Lite address phase capture
  // ---------------------------------------------------------------
  logic        dph_write;
  logic [7:0]  dph_addr;
  logic        addr_take;

  assign addr_take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_write <= 1'b0;
      dph_addr  <= 8'h00;
    end else begin
      dph_write <= addr_take && hwrite;
      dph_addr  <= haddr[7:0];
    end
  end

  // zero wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  logic wr_core;
  logic wr_trap;
  logic wr_status;

  assign wr_core   = dph_write && (dph_addr == macdp_pkg::CORE_CTRL_OFS);
  assign wr_trap   = dph_write && (dph_addr == macdp_pkg::TRAP_CTRL_OFS);
  assign wr_status = dph_write && (dph_addr == macdp_pkg::STATUS_OFS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_control_reg <= macdp_pkg::CORE_CTRL_RST;
      trap_control_reg <= macdp_pkg::TRAP_CTRL_RST;
    end else begin
      if (wr_core) begin
        core_control_reg <= hwdata[3:0];
      end
      if (wr_trap) begin
        trap_control_reg <= hwdata[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // multiplier and scaler
  // ---------------------------------------------------------------
  logic [15:0]        x_sized;
  logic [15:0]        y_sized;
  logic signed [16:0] x_ext;
  logic signed [16:0] y_ext;
  logic signed [33:0] product;
  logic [32:0]        scaled;
  logic [39:0]        product40;
  logic               is_mul;

  assign is_mul = (op_code == macdp_pkg::MACDP_OP_MUL);

  // byte operands are widened with the same sign choice
  always_comb begin
    if (is_mul && byte_operands) begin
      x_sized = {{8{x_signed & x_operand[7]}}, x_operand[7:0]};
      y_sized = {{8{y_signed & y_operand[7]}}, y_operand[7:0]};
    end else begin
      x_sized = x_operand;
      y_sized = y_operand;
    end
  end

  assign x_ext   = ext17(x_sized, x_signed);
  assign y_ext   = ext17(y_sized, y_signed);
  assign product = x_ext * y_ext;

  // fractional mode shifts left once so 1.15 x 1.15 lands as 1.31
  always_comb begin
    if (frac_mode && !is_mul) begin
      scaled = {product[31:0], 1'b0};
    end else begin
      scaled = product[32:0];
    end
  end

  assign product40 = {{7{scaled[32]}}, scaled};

  // ---------------------------------------------------------------
  // adder/subtracter
  // ---------------------------------------------------------------
  logic        acc_op;
  logic [39:0] acc_src;
  logic [39:0] add_data;
  logic [39:0] in_a;
  logic [39:0] in_b;
  logic        carry_in;
  logic [40:0] sum41;
  logic        cat_ovf;
  logic        neg_dir;
  logic        sat_en;
  logic        sat_ovf;
  logic        sat_flag;
  logic [39:0] result;

  assign acc_op = op_valid && ((op_code == macdp_pkg::MACDP_OP_MAC)
                            || (op_code == macdp_pkg::MACDP_OP_ADD)
                            || (op_code == macdp_pkg::MACDP_OP_LAC));

  assign acc_src = acc_select_b ? accumulator_b : accumulator_a;

  always_comb begin
    if (op_code == macdp_pkg::MACDP_OP_MAC) begin
      add_data = product40;
    end else begin
      add_data = use_shifted_data ? shifted_data : raw_data;
    end
  end

  // load zeroes the accumulator side; subtract complements with no borrow
  assign in_a     = (op_code == macdp_pkg::MACDP_OP_LAC) ? 40'h00_0000_0000 : acc_src;
  assign in_b     = (op_subtract && op_code != macdp_pkg::MACDP_OP_LAC) ? ~add_data
                                                                        : add_data;
  assign carry_in = op_subtract && (op_code != macdp_pkg::MACDP_OP_LAC);
  assign sum41    = {in_a[39], in_a} + {in_b[39], in_b} + {40'h00_0000_0000, carry_in};

  // extra sign bit disagrees with bit 39 when the sign was lost
  assign cat_ovf = sum41[40] ^ sum41[39];
  assign neg_dir = sum41[40];

  // ---------------------------------------------------------------
  // saturation
  // ---------------------------------------------------------------
  assign sat_en  = acc_select_b ? per_acc_saturation_enable[1]
                                : per_acc_saturation_enable[0];
  assign sat_ovf = wide_saturation_select ? cat_ovf
                                          : (cat_ovf || !fits32(sum41[39:0]));

  always_comb begin
    result = sum41[39:0];
    if (sat_en && sat_ovf) begin
      if (wide_saturation_select) begin
        result = neg_dir ? macdp_pkg::MIN40 : macdp_pkg::MAX40;
      end else begin
        result = neg_dir ? macdp_pkg::MIN32 : macdp_pkg::MAX32;
      end
    end
  end

  assign sat_flag = sat_en ? sat_ovf : cat_ovf;

  // ---------------------------------------------------------------
  // accumulators and multiply result
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accumulator_a <= macdp_pkg::ACC_RST;
      accumulator_b <= macdp_pkg::ACC_RST;
    end else if (acc_op) begin
      if (acc_select_b) begin
        accumulator_b <= result;
      end else begin
        accumulator_a <= result;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mul_result <= 32'h0000_0000;
      mul_done   <= 1'b0;
    end else begin
      mul_done <= op_valid && is_mul;
      if (op_valid && is_mul) begin
        if (byte_operands) begin
          mul_result <= {16'h0000, product[15:0]};
        end else begin
          mul_result <= product[31:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic new_oa;
  logic new_ob;
  logic set_sa;
  logic set_sb;
  logic clr_sa;
  logic clr_sb;
  logic next_oa;
  logic next_ob;
  logic next_sa;
  logic next_sb;

  // guard flags follow the value actually written back
  assign new_oa = guard_mixed(result);
  assign new_ob = guard_mixed(result);
  assign set_sa = acc_op && !acc_select_b && sat_flag;
  assign set_sb = acc_op && acc_select_b && sat_flag;
  // writing zero clears; a hardware set in the same cycle still wins
  assign clr_sa = wr_status && !hwdata[macdp_pkg::ST_SA_BIT];
  assign clr_sb = wr_status && !hwdata[macdp_pkg::ST_SB_BIT];

  always_comb begin
    next_oa = acc_a_guard_overflow;
    next_ob = acc_b_guard_overflow;
    if (acc_op && !acc_select_b) begin
      next_oa = new_oa;
    end
    if (acc_op && acc_select_b) begin
      next_ob = new_ob;
    end
    next_sa = set_sa || (acc_a_saturated && !clr_sa);
    next_sb = set_sb || (acc_b_saturated && !clr_sb);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_a_guard_overflow <= 1'b0;
      acc_b_guard_overflow <= 1'b0;
      acc_a_saturated      <= 1'b0;
      acc_b_saturated      <= 1'b0;
      any_guard_overflow   <= 1'b0;
      any_saturated        <= 1'b0;
    end else begin
      acc_a_guard_overflow <= next_oa;
      acc_b_guard_overflow <= next_ob;
      acc_a_saturated      <= next_sa;
      acc_b_saturated      <= next_sb;
      any_guard_overflow   <= next_oa || next_ob;
      any_saturated        <= next_sa || next_sb;
    end
  end

  // ---------------------------------------------------------------
  // arithmetic warning trap, one-cycle pulse per offending pass
  // ---------------------------------------------------------------
  logic trap_guard;
  logic trap_cat;

  assign trap_guard = acc_op && ((!acc_select_b && new_oa && acc_a_overflow_trap_en)
                              || (acc_select_b && new_ob && acc_b_overflow_trap_en));
  assign trap_cat   = acc_op && !sat_en && sat_flag
                      && catastrophic_overflow_trap_en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arith_warning_trap <= 1'b0;
    end else begin
      arith_warning_trap <= trap_guard || trap_cat;
    end
  end

  // ---------------------------------------------------------------
  // read data, sampled at the address phase so it stands from a flop
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    case (haddr[7:0])
      macdp_pkg::CORE_CTRL_OFS: rd_mux = {28'h000_0000, core_control_reg};
      macdp_pkg::TRAP_CTRL_OFS: rd_mux = {29'h0000_0000, trap_control_reg};
      macdp_pkg::STATUS_OFS:    rd_mux = {26'h000_0000, any_saturated, any_guard_overflow,
                                          acc_b_saturated, acc_a_saturated,
                                          acc_b_guard_overflow, acc_a_guard_overflow};
      macdp_pkg::ACC_A_LO_OFS:  rd_mux = accumulator_a[31:0];
      macdp_pkg::ACC_A_HI_OFS:  rd_mux = {24'h00_0000, accumulator_a[39:32]};
      macdp_pkg::ACC_B_LO_OFS:  rd_mux = accumulator_b[31:0];
      macdp_pkg::ACC_B_HI_OFS:  rd_mux = {24'h00_0000, accumulator_b[39:32]};
      macdp_pkg::MUL_RES_OFS:   rd_mux = mul_result;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  // limitation: a flag changing in the data-phase cycle shows next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

endmodule

// ===== rtl/macdp_pkg.sv
// constants for the multiply-accumulate datapath
package macdp_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CORE_CTRL_OFS  = 8'h00;
  localparam logic [7:0] TRAP_CTRL_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS     = 8'h08;
  localparam logic [7:0] ACC_A_LO_OFS   = 8'h0C;
  localparam logic [7:0] ACC_A_HI_OFS   = 8'h10;
  localparam logic [7:0] ACC_B_LO_OFS   = 8'h14;
  localparam logic [7:0] ACC_B_HI_OFS   = 8'h18;
  localparam logic [7:0] MUL_RES_OFS    = 8'h1C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SAT_EN_A_BIT   = 0;
  localparam int SAT_EN_B_BIT   = 1;
  localparam int WIDE_SAT_BIT   = 2;
  localparam int FRAC_MODE_BIT  = 3;
  localparam int OVA_TRAP_BIT   = 0;
  localparam int OVB_TRAP_BIT   = 1;
  localparam int COV_TRAP_BIT   = 2;
  localparam int ST_OA_BIT      = 0;
  localparam int ST_OB_BIT      = 1;
  localparam int ST_SA_BIT      = 2;
  localparam int ST_SB_BIT      = 3;
  localparam int ST_OAB_BIT     = 4;
  localparam int ST_SAB_BIT     = 5;

  // ---------------------------------------------------------------
  // reset values and saturation limits
  // ---------------------------------------------------------------
  localparam logic [3:0]  CORE_CTRL_RST = 4'h0;
  localparam logic [2:0]  TRAP_CTRL_RST = 3'h0;
  localparam logic [39:0] ACC_RST       = 40'h00_0000_0000;
  localparam logic [39:0] MAX40         = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] MIN40         = 40'h80_0000_0000;
  localparam logic [39:0] MAX32         = 40'h00_7FFF_FFFF;
  localparam logic [39:0] MIN32         = 40'hFF_8000_0000;

  // ---------------------------------------------------------------
  // operations issued by the core
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MACDP_OP_NONE = 3'b000,
    MACDP_OP_MAC  = 3'b001,
    MACDP_OP_ADD  = 3'b010,
    MACDP_OP_LAC  = 3'b011,
    MACDP_OP_MUL  = 3'b100
  } macdp_op_e;

endpackage

// ===== bench/macdp_core_model.sv
// behavioural model of the core decode logic that drives the op port
`timescale 1ns/1ns

module macdp_core_model (
  input  wire logic        hclk,
  output logic             op_valid,
  output logic [2:0]       op_code,
  output logic             acc_select_b,
  output logic             op_subtract,
  output logic             x_signed,
  output logic             y_signed,
  output logic             byte_operands,
  output logic [15:0]      x_operand,
  output logic [15:0]      y_operand,
  output logic             use_shifted_data,
  output logic [39:0]      raw_data,
  output logic [39:0]      shifted_data
);
  initial begin
    op_valid = 1'b0;
    {op_code, acc_select_b, op_subtract, x_signed, y_signed, byte_operands} = '0;
    {x_operand, y_operand, use_shifted_data, raw_data, shifted_data} = '0;
  end

  // call just after an edge; the op is taken at the next edge, fields stand until then
  task automatic issue(input logic [2:0] c, input logic [5:0] f, input logic [15:0] x,
                       input logic [15:0] y, input logic [39:0] r, input logic [39:0] s);
    op_valid <= 1'b1;
    op_code <= c;
    {acc_select_b, op_subtract, x_signed, y_signed, byte_operands, use_shifted_data} <= f;
    x_operand <= x;
    y_operand <= y;
    raw_data <= r;
    shifted_data <= s;
    @(posedge hclk);
  endtask

  // idle inverts x_operand, raw_data and shifted_data so a stale value is never mistaken for data
  task automatic idle();
    op_valid <= 1'b0;
    op_code <= 3'h0;
    x_operand <= ~x_operand;
    raw_data <= ~raw_data;
    shifted_data <= ~shifted_data;
  endtask
endmodule

// ===== bench/macdp_asserts.sv
// concurrent checks on the ports of the multiply-accumulate datapath
`timescale 1ns/1ns

module macdp_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        op_valid,
  input wire logic [2:0]  op_code,
  input wire logic        acc_select_b,
  input wire logic        x_signed,
  input wire logic        y_signed,
  input wire logic        byte_operands,
  input wire logic [15:0] x_operand,
  input wire logic [15:0] y_operand,
  input wire logic        use_shifted_data,
  input wire logic [39:0] raw_data,
  input wire logic [39:0] accumulator_a,
  input wire logic [39:0] accumulator_b,
  input wire logic [31:0] mul_result,
  input wire logic        mul_done,
  input wire logic        acc_a_guard_overflow,
  input wire logic        acc_b_guard_overflow,
  input wire logic        acc_a_saturated,
  input wire logic        acc_b_saturated,
  input wire logic        any_guard_overflow,
  input wire logic        any_saturated,
  input wire logic        arith_warning_trap
);
  logic add_op;
  logic st_wr;
  assign add_op = op_valid && (op_code inside {3'h1, 3'h2, 3'h3});
  assign st_wr = hsel && hready && htrans[1] && hwrite && haddr[7:0] == macdp_pkg::STATUS_OFS;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_a_pass; add_op && !acc_select_b; endsequence
  sequence s_b_pass; add_op && acc_select_b; endsequence
  sequence s_mul; op_valid && op_code == macdp_pkg::MACDP_OP_MUL; endsequence
  sequence s_lac_small;
    op_valid && op_code == macdp_pkg::MACDP_OP_LAC && !use_shifted_data
      && (raw_data[39:31] inside {9'h000, 9'h1FF});
  endsequence

  property p_guard_a; s_a_pass |=> acc_a_guard_overflow == !(accumulator_a[39:32] inside {8'h00, 8'hFF}); endproperty
  property p_guard_b; s_b_pass |=> acc_b_guard_overflow == !(accumulator_b[39:32] inside {8'h00, 8'hFF}); endproperty
  property p_any_ovf; any_guard_overflow == (acc_a_guard_overflow | acc_b_guard_overflow); endproperty
  property p_any_sat; any_saturated == (acc_a_saturated | acc_b_saturated); endproperty
  property p_hold_a; s_b_pass |=> $stable(accumulator_a) && $stable(acc_a_guard_overflow); endproperty
  property p_sticky_a;
    acc_a_saturated ##1 !acc_a_saturated |-> $past(st_wr, 2) && !$past(hwdata[macdp_pkg::ST_SA_BIT]);
  endproperty
  property p_lac;
    s_lac_small |=> ($past(acc_select_b) ? accumulator_b : accumulator_a) == $past(raw_data);
  endproperty
  property p_mul_u;
    s_mul and (!x_signed && !y_signed && !byte_operands) |=>
      mul_done && mul_result == $past(x_operand) * $past(y_operand);
  endproperty
  property p_mul_s;
    s_mul and (x_signed && y_signed && !byte_operands) |=>
      $signed(mul_result) == $signed($past(x_operand)) * $signed($past(y_operand));
  endproperty
  property p_mul_byte; s_mul and byte_operands |=> mul_done && mul_result[31:16] == 16'h0000; endproperty
  property p_trap; arith_warning_trap |-> $past(add_op) && (any_guard_overflow || any_saturated); endproperty

  a_guard_a: assert property (p_guard_a) else $error("guard flag A disagrees with accumulator A");
  a_guard_b: assert property (p_guard_b) else $error("guard flag B disagrees with accumulator B");
  a_any_ovf: assert property (p_any_ovf) else $error("combined guard flag wrong");
  a_any_sat: assert property (p_any_sat) else $error("combined saturation flag wrong");
  a_hold_a: assert property (p_hold_a) else $error("accumulator A changed on a B pass");
  a_sticky_a: assert property (p_sticky_a) else $error("saturation A cleared without a write");
  a_lac: assert property (p_lac) else $error("load did not place the data");
  a_mul_u: assert property (p_mul_u) else $error("unsigned product wrong");
  a_mul_s: assert property (p_mul_s) else $error("signed product wrong");
  a_mul_byte: assert property (p_mul_byte) else $error("byte product wider than 16 bits");
  a_trap: assert property (p_trap) else $error("trap without an overflowing adder pass");
endmodule

bind macdp_top macdp_asserts macdp_asserts_i (.*);

// ===== bench/macdp_tb_top.sv
// self-checking testbench of the multiply-accumulate datapath
`timescale 1ns/1ns

module macdp_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pend;
  logic [31:0] haddr, hwdata, hrdata, mul_result, m_mul, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, op_code, m_trp;
  logic [3:0]  m_ctrl;
  logic        op_valid, acc_select_b, op_subtract, x_signed, y_signed, byte_operands;
  logic        use_shifted_data, mul_done, arith_warning_trap, any_guard_overflow;
  logic        acc_a_guard_overflow, acc_b_guard_overflow, acc_a_saturated, acc_b_saturated;
  logic        any_saturated;
  logic [15:0] x_operand, y_operand;
  logic [39:0] raw_data, shifted_data, accumulator_a, accumulator_b;
  int          num_errors, samples_checked, seed;
  longint      m_acc [2];
  bit          m_go [2], m_sa [2], m_done, m_trap;

  assign hready = hreadyout;
  macdp_top macdp_top_i (.*);
  macdp_core_model macdp_core_model_i (.hclk(hclk), .op_valid(op_valid), .op_code(op_code),
    .acc_select_b(acc_select_b), .op_subtract(op_subtract), .x_signed(x_signed),
    .y_signed(y_signed), .byte_operands(byte_operands), .x_operand(x_operand),
    .y_operand(y_operand), .use_shifted_data(use_shifted_data), .raw_data(raw_data),
    .shifted_data(shifted_data));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ---------------------------------------------------------------
  // reference model and checking
  // ---------------------------------------------------------------
  function automatic longint sx(longint v, int w);
    return (v <<< (64 - w)) >>> (64 - w);
  endfunction

  function automatic longint ex(longint v, int w, bit s);
    return s ? sx(v, w) : v & ((64'sh1 <<< w) - 1);
  endfunction

  function automatic logic [31:0] st_exp();
    return {26'h0, m_sa[0] | m_sa[1], m_go[0] | m_go[1], m_sa[1], m_sa[0], m_go[1], m_go[0]};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // results of the op taken at the last edge are settled by the falling edge
  always @(negedge hclk) begin
    if (pend) begin
      pend = 1'b0;
      check(accumulator_a, m_acc[0][39:0]);
      check(accumulator_b, m_acc[1][39:0]);
      check(mul_result, m_mul);
      check(mul_done, m_done);
      check(arith_warning_trap, m_trap);
      check({any_saturated, any_guard_overflow, acc_b_saturated, acc_a_saturated,
             acc_b_guard_overflow, acc_a_guard_overflow}, st_exp());
    end
  end

  task automatic do_op(input logic [2:0] c, input logic [5:0] f, input logic [15:0] x,
                       input logic [15:0] y, input logic [39:0] r, input logic [39:0] s);
    longint p, d, t, lim, top;
    int k, w;
    bit en, ov, cat;
    macdp_core_model_i.issue(c, f, x, y, r, s);
    k = f[5];
    w = (f[1] && c == 3'h4) ? 8 : 16;
    p = ex(x, w, f[3]) * ex(y, w, f[2]);
    en = m_ctrl[k];
    top = 64'sh1 <<< 39;
    lim = (en && !m_ctrl[macdp_pkg::WIDE_SAT_BIT]) ? 64'sh1 <<< 31 : top;
    // the scaled product is a 33-bit signed value before it is widened
    d = sx(m_ctrl[macdp_pkg::FRAC_MODE_BIT] ? p <<< 1 : p, 33);
    if (c != 3'h1)
      d = sx(f[0] ? s : r, 40);
    t = (c == 3'h3) ? d : (f[4] ? m_acc[k] - d : m_acc[k] + d);
    cat = t >= top || t < -top;
    ov = t >= lim || t < -lim;
    m_done = (c == 3'h4);
    m_trap = 1'b0;
    if (c == 3'h4)
      m_mul = f[1] ? {16'h0000, p[15:0]} : p[31:0];
    if (c inside {3'h1, 3'h2, 3'h3}) begin
      m_acc[k] = (en && ov) ? (t < 0 ? -lim : lim - 1) : sx(t, 40);
      m_sa[k] = m_sa[k] | ov;
      m_go[k] = !((m_acc[k] >>> 32) inside {64'sh0, -64'sh1});
      m_trap = (m_go[k] && m_trp[k]) || (cat && !en && m_trp[2]);
    end
    pend = 1'b1;
  endtask

  // ---------------------------------------------------------------
  // register bus master
  // ---------------------------------------------------------------
  task automatic wait_ready(inout int n);
    @(posedge hclk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(n);
    rd = hrdata;
    check(hresp, 1'b0);
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
    if (a == macdp_pkg::CORE_CTRL_OFS)
      m_ctrl = d[3:0];
    if (a == macdp_pkg::TRAP_CTRL_OFS)
      m_trp = d[2:0];
    if (a == macdp_pkg::STATUS_OFS)
      m_sa = '{m_sa[0] & d[macdp_pkg::ST_SA_BIT], m_sa[1] & d[macdp_pkg::ST_SB_BIT]};
  endtask

  task automatic regs_chk();
    rd_chk(macdp_pkg::CORE_CTRL_OFS, {28'h0, m_ctrl});
    rd_chk(macdp_pkg::TRAP_CTRL_OFS, {29'h0, m_trp});
    rd_chk(macdp_pkg::STATUS_OFS, st_exp());
    rd_chk(macdp_pkg::ACC_A_LO_OFS, m_acc[0][31:0]);
    rd_chk(macdp_pkg::ACC_A_HI_OFS, {24'h0, m_acc[0][39:32]});
    rd_chk(macdp_pkg::ACC_B_LO_OFS, m_acc[1][31:0]);
    rd_chk(macdp_pkg::ACC_B_HI_OFS, {24'h0, m_acc[1][39:32]});
    rd_chk(macdp_pkg::MUL_RES_OFS, m_mul);
    rd_chk(8'h20, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 8;
    num_errors = 0;
    samples_checked = 0;
    {m_ctrl, m_trp, m_mul} = '0;
    pend = 1'b1;
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    regs_chk();
    wr(macdp_pkg::ACC_A_LO_OFS, 32'hFFFF_FFFF);
    wr(8'h24, 32'hFFFF_FFFF);
    for (int cfg = 0; cfg < 16; cfg++) begin
      wr(macdp_pkg::CORE_CTRL_OFS, 32'(cfg));
      wr(macdp_pkg::TRAP_CTRL_OFS, 32'($random(seed)));
      do_op(3'h3, 6'h00, 16'h0000, 16'h0000, 40'h00_0000_1234, 40'h0);
      do_op(3'h1, 6'h0C, 16'h8000, 16'h8000, 40'h0, 40'h0);
      do_op(3'h3, 6'h00, 16'h0000, 16'h0000, 40'h7F_FFFF_FFFF, 40'h0);
      do_op(3'h2, 6'h00, 16'h0000, 16'h0000, 40'h1, 40'h0);
      do_op(3'h3, 6'h21, 16'h0000, 16'h0000, 40'h0, 40'hFF_8000_0000);
      do_op(3'h2, 6'h30, 16'h0000, 16'h0000, 40'h1, 40'h0);
      do_op(3'h4, 6'h0C, 16'h8000, 16'hFFFF, 40'h0, 40'h0);
      do_op(3'h4, 6'h08, 16'hFFFF, 16'hFFFF, 40'h0, 40'h0);
      do_op(3'h4, 6'h02, 16'h12FF, 16'h34FF, 40'h0, 40'h0);
      repeat (40) begin
        do_op(3'($random(seed)), 6'($random(seed)), 16'($random(seed)), 16'($random(seed)),
              {8'($random(seed)), 32'($random(seed))}, 40'($random(seed)));
      end
      macdp_core_model_i.idle();
      regs_chk();
      wr(macdp_pkg::STATUS_OFS, 32'($random(seed)));
      regs_chk();
    end
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge hclk);
    num_errors++;
    give_verdict();
  end
endmodule
